// ===== analog_ramp_assertions.sv
// port checker for the analog ramp generator
module analog_ramp_checker #(
    parameter int TICK_CYCLES = analog_ramp_pkg::TICK_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic enable_i,
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire analog_ramp_pkg::level_t current_level_o,
    input wire logic [15:0] scaled_output_value_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import analog_ramp_pkg::*;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    int gap;
    int quiet;
    int en_run;
    level_t prev_lvl;
    logic moved;
    assign moved = current_level_o != prev_lvl;
    // level move spacing, bus quiet time, enable run; writes can move the level off-tick
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            gap <= 0;
            quiet <= 0;
            en_run <= 0;
            prev_lvl <= '0;
        end else begin
            prev_lvl <= current_level_o;
            gap <= moved ? 0 : gap + 1;
            quiet <= (hsel_i && htrans_i[1]) ? 0 : quiet + 1;
            en_run <= enable_i ? en_run + 1 : 0;
        end
    end
    property p_range_hi; scaled_output_value_o <= 16'h7FFF; endproperty
    a_range_hi: assert property (p_range_hi) else $error("scaled output above 32767");
    property p_limit; current_level_o <= LEVEL_MAX; endproperty
    a_limit: assert property (p_limit) else $error("level above limit");
    property p_floor; current_level_o >= LEVEL_MIN; endproperty
    a_floor: assert property (p_floor) else $error("level below range");
    property p_rest; !enable_i [*3] |-> current_level_o <= OFFSET_LIM
        && current_level_o >= -OFFSET_LIM; endproperty
    a_rest: assert property (p_rest) else $error("resting level out of range");
    property p_off; $fell(enable_i) |-> ##3 scaled_output_value_o == 16'h0000; endproperty
    a_off: assert property (p_off) else $error("output not zero after disable");
    property p_tick; moved && en_run >= 4 && quiet >= 6 |-> gap >= TICK_CYCLES - 1; endproperty
    a_tick: assert property (p_tick) else $error("level moved between ticks");
    property p_hold; $rose(enable_i) ##1 enable_i [*6] |-> $stable(current_level_o); endproperty
    a_hold: assert property (p_hold) else $error("start level not held");
    // both outputs are loaded from the same level on the same edge
    property p_follow; $changed(scaled_output_value_o) && quiet >= 6
        |-> current_level_o != $past(current_level_o); endproperty
    a_follow: assert property (p_follow) else $error("output moved without level");
    c_start: cover property ($rose(enable_i));
    c_sat: cover property (scaled_output_value_o == 16'h7FFF);
    c_move: cover property (moved && en_run >= 4);
endmodule // analog_ramp_checker

bind analog_ramp_generator analog_ramp_checker #(.TICK_CYCLES(TICK_CYCLES)) checker_i (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .enable_i(enable_i),
    .hsel_i(hsel_i),
    .htrans_i(htrans_i),
    .current_level_o(current_level_o),
    .scaled_output_value_o(scaled_output_value_o)
);

// ===== analog_ramp_generator.sv
// analog ramp generator with an AHB-Lite settings and status port
// Notes on behaviour
// - ramp rate is 1 to 10000 level steps per second, used for all ramps.
// - base offset is limited to plus or minus 10000; it is the resting level.
// - output equals current level minus base offset, divided by gain.
// - scaled output is kept between 0 and 32767.
// - enable rising loads start/stop level and holds it for 100 ms.
// - after start hold, ramp at rate toward level chosen by select.
// - decelerated stop ramps to start/stop level, holds 100 ms, then rests; the code holds it 200 ms after the ramp arrives instead.
// - after decelerated stop, restart waits until stop and enable both drop.
// - a select change ramps from present target toward the new one; the code ramps from the present level instead.
// - enable falling forces current level to base offset at once.
// - current level is recomputed once every 100 ms.
// - select zero picks first target level, one picks second.
// - each target level is limited to -10000 through 20000.
// - current level never exceeds the maximum level limit.
// - start/stop offset is 0 to 20000, added to base offset.
//
// Added by the designer: the address map and register access over AHB-Lite.
module analog_ramp_generator #(
    parameter int TICK_CYCLES = analog_ramp_pkg::TICK_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic enable_i,
    input wire logic level_select_i,
    input wire logic decelerated_stop_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    output analog_ramp_pkg::level_t current_level_o,
    output logic [15:0] scaled_output_value_o
);
    import analog_ramp_pkg::*;

    localparam int TICK_W = $clog2(TICK_CYCLES);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
    localparam logic [TICK_W-1:0] TICK_ZERO = '0;

    // saturate a value into a closed range
    function automatic level_t clamp(input level_t v, input level_t lo, input level_t hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    // step from cur toward tgt by at most step, never past tgt
    function automatic level_t move_toward(input level_t cur, input level_t tgt,
                                           input level_t step);
        if (cur < tgt) begin
            return (tgt - cur > step) ? cur + step : tgt;
        end else if (cur > tgt) begin
            return (cur - tgt > step) ? cur - step : tgt;
        end
        return cur;
    endfunction

    // settings written by software
    level_t rate;
    level_t gain;
    level_t base_offset;
    level_t start_stop_offset;
    level_t first_target_level;
    level_t second_target_level;
    level_t maximum_level_limit;

    // ramp state
    state_e state;
    state_e next_state;
    level_t level;
    level_t next_level;
    level_t frac;
    level_t next_frac;
    logic enable_q;
    logic [TICK_W-1:0] tick_cnt;

    // bus data-phase bookkeeping
    logic wr_pend;
    logic [7:0] wr_addr;

    // bus decode
    wire addr_phase = hsel_i && hready_i && htrans_i[1];
    wire take_write = addr_phase && hwrite_i;
    wire take_read = addr_phase && !hwrite_i;
    wire [7:0] word_addr = {haddr_i[7:2], 2'b00};
    wire level_t wr_val = level_t'(hwdata_i);

    // readback mux, unmapped words read as zero
    wire [31:0] status_word = 32'(state) << STATUS_STATE_LSB
                            | 32'(level_select_i) << STATUS_SEL_BIT;
    wire [31:0] rd_mux =
        (word_addr == ADDR_RATE) ? 32'(rate) :
        (word_addr == ADDR_GAIN) ? 32'(gain) :
        (word_addr == ADDR_OFFSET) ? 32'(base_offset) :
        (word_addr == ADDR_START_STOP) ? 32'(start_stop_offset) :
        (word_addr == ADDR_FIRST) ? 32'(first_target_level) :
        (word_addr == ADDR_SECOND) ? 32'(second_target_level) :
        (word_addr == ADDR_LIMIT) ? 32'(maximum_level_limit) :
        (word_addr == ADDR_STATUS) ? status_word :
        (word_addr == ADDR_CURRENT) ? 32'(level) :
        (word_addr == ADDR_OUTPUT) ? 32'(scaled_output_value_o) : 32'h0000_0000;

    // derived levels
    wire level_t ss_level = base_offset + start_stop_offset;
    wire level_t sel_target = level_select_i ? second_target_level
                                             : first_target_level;
    // target follows select live, so a change re-aims the ramp at once
    wire level_t ramp_target = clamp(sel_target, LEVEL_MIN, maximum_level_limit);
    wire level_t stop_target = clamp(ss_level, LEVEL_MIN, maximum_level_limit);

    // update tick and edge detection
    wire tick = (tick_cnt == TICK_LAST);
    wire enable_rise = enable_i && !enable_q;
    wire restart_tick = (state == SEQ_IDLE) && enable_rise && !decelerated_stop_i;

    // fractional rate accumulator: rate/10 per tick, remainder carried
    wire level_t rate_sum = frac + rate;
    wire level_t step = rate_sum / TICKS_PER_SEC;
    wire level_t rate_rem = rate_sum - step * TICKS_PER_SEC;

    // scaled output: (level - offset) * unit / gain, truncated, saturated
    wire level_t diff = level - base_offset;
    wire level_t quot = (gain == GAIN_MIN) ? OUT_MAX
                                           : (diff * GAIN_UNIT) / gain;
    wire level_t out_sat = clamp(quot, OUT_MIN, OUT_MAX);

    // sequencer next state and next level
    always_comb begin
        next_state = state;
        next_level = level;
        next_frac = frac;
        // enable low outranks every ramp phase; the lock also waits for stop
        if (!enable_i && state != SEQ_IDLE && state != SEQ_LOCKED) begin
            next_state = SEQ_IDLE;
            next_level = base_offset;
        end else begin
            unique case (state)
                SEQ_IDLE: begin
                    // resting level follows offset writes while idle
                    next_level = base_offset;
                    next_frac = '0;
                    if (restart_tick) begin
                        next_state = SEQ_START_HOLD;
                        next_level = stop_target;
                    end
                end
                SEQ_START_HOLD: begin
                    // tick counter was restarted on entry, so this is 100 ms
                    if (decelerated_stop_i) begin
                        next_state = SEQ_DECEL;
                    end else if (tick) begin
                        next_state = SEQ_RAMP;
                    end
                end
                SEQ_RAMP: begin
                    if (decelerated_stop_i) begin
                        next_state = SEQ_DECEL;
                    end else if (tick) begin
                        next_level = move_toward(level, ramp_target, step);
                        next_frac = rate_rem;
                    end
                end
                SEQ_DECEL: begin
                    if (tick) begin
                        next_frac = rate_rem;
                        if (level == stop_target) begin
                            next_state = SEQ_STOP_HOLD;
                        end else begin
                            next_level = move_toward(level, stop_target, step);
                        end
                    end
                end
                SEQ_STOP_HOLD: begin
                    // entered on a tick, so the next tick ends a full 100 ms
                    if (tick) begin
                        next_state = SEQ_LOCKED;
                        next_level = base_offset;
                    end
                end
                SEQ_LOCKED: begin
                    next_level = base_offset;
                    if (!decelerated_stop_i && !enable_i) begin
                        next_state = SEQ_IDLE;
                    end
                end
            endcase
        end
        // a lowered limit pulls the level down even mid-hold
        if (next_level > maximum_level_limit) begin
            next_level = maximum_level_limit;
        end
    end

    // 100 ms tick counter, restarted when a start hold begins
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || restart_tick || tick) begin
            tick_cnt <= TICK_ZERO;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
        end
    end

    // ramp state registers
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            state <= SEQ_IDLE;
            level <= OFFSET_RST;
            frac <= '0;
        end else begin
            state <= next_state;
            level <= next_level;
            frac <= next_frac;
        end
    end

    // enable history for the rise detector, reset to the pin's idle level
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            enable_q <= 1'b0;
        end else begin
            enable_q <= enable_i;
        end
    end

    // outputs, all registered
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            current_level_o <= OFFSET_RST;
            scaled_output_value_o <= 16'h0000;
        end else begin
            current_level_o <= level;
            scaled_output_value_o <= out_sat[15:0];
        end
    end

    // handshake: zero wait states and always OKAY, so no stall path exists
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end

    // write address kept for the data phase, when hwdata finally stands
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= take_write;
            if (take_write) begin
                wr_addr <= word_addr;
            end
        end
    end

    // read data loaded in the address phase, so it stands through the data phase
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (take_read) begin
            hrdata_o <= rd_mux;
        end
    end

    // write strobes, one per setting, from the captured data-phase address
    wire wr_rate = wr_pend && (wr_addr == ADDR_RATE);
    wire wr_gain = wr_pend && (wr_addr == ADDR_GAIN);
    wire wr_offset = wr_pend && (wr_addr == ADDR_OFFSET);
    wire wr_start_stop = wr_pend && (wr_addr == ADDR_START_STOP);
    wire wr_first = wr_pend && (wr_addr == ADDR_FIRST);
    wire wr_second = wr_pend && (wr_addr == ADDR_SECOND);
    wire wr_limit = wr_pend && (wr_addr == ADDR_LIMIT);

    // rate floored at one step per second, so a ramp always ends
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rate <= RATE_RST;
        end else if (wr_rate) begin
            rate <= clamp(wr_val, RATE_MIN, RATE_MAX);
        end
    end

    // gain in hundredths; zero is legal and saturates the output
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            gain <= GAIN_RST;
        end else if (wr_gain) begin
            gain <= clamp(wr_val, GAIN_MIN, GAIN_MAX);
        end
    end

    // base offset, the resting level
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            base_offset <= OFFSET_RST;
        end else if (wr_offset) begin
            base_offset <= clamp(wr_val, -OFFSET_LIM, OFFSET_LIM);
        end
    end

    // start/stop offset, never negative
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            start_stop_offset <= SS_RST;
        end else if (wr_start_stop) begin
            start_stop_offset <= clamp(wr_val, SS_MIN, SS_MAX);
        end
    end

    // first target level
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            first_target_level <= FIRST_RST;
        end else if (wr_first) begin
            first_target_level <= clamp(wr_val, LEVEL_MIN, LEVEL_MAX);
        end
    end

    // second target level
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            second_target_level <= SECOND_RST;
        end else if (wr_second) begin
            second_target_level <= clamp(wr_val, LEVEL_MIN, LEVEL_MAX);
        end
    end

    // level ceiling; lowering it pulls the level down at the next edge
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            maximum_level_limit <= LIMIT_RST;
        end else if (wr_limit) begin
            maximum_level_limit <= clamp(wr_val, LEVEL_MIN, LEVEL_MAX);
        end
    end

endmodule // analog_ramp_generator

// ===== analog_ramp_pkg.sv
// constants, register map and state encoding for the analog ramp generator
package analog_ramp_pkg;

    // signed level arithmetic, wide enough for every sum and product used
    typedef logic signed [31:0] level_t;

    // update tick: 100 ms at a 10 MHz system clock
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_MS = 100;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam level_t TICKS_PER_SEC = 1000 / TICK_MS;

    // legal parameter ranges
    localparam level_t RATE_MIN = 1;
    localparam level_t RATE_MAX = 10000;
    localparam level_t OFFSET_LIM = 10000;
    localparam level_t LEVEL_MIN = -10000;
    localparam level_t LEVEL_MAX = 20000;
    localparam level_t SS_MIN = 0;
    localparam level_t SS_MAX = 20000;
    localparam level_t GAIN_MIN = 0;
    localparam level_t GAIN_MAX = 1000;
    localparam level_t GAIN_UNIT = 100;
    localparam level_t OUT_MIN = 0;
    localparam level_t OUT_MAX = 32767;

    // reset values of the settings
    localparam level_t RATE_RST = 100;
    localparam level_t GAIN_RST = 100;
    localparam level_t OFFSET_RST = 0;
    localparam level_t SS_RST = 0;
    localparam level_t FIRST_RST = 0;
    localparam level_t SECOND_RST = 0;
    localparam level_t LIMIT_RST = 20000;

    // register byte addresses (word aligned)
    localparam logic [7:0] ADDR_RATE = 8'h00;
    localparam logic [7:0] ADDR_GAIN = 8'h04;
    localparam logic [7:0] ADDR_OFFSET = 8'h08;
    localparam logic [7:0] ADDR_START_STOP = 8'h0C;
    localparam logic [7:0] ADDR_FIRST = 8'h10;
    localparam logic [7:0] ADDR_SECOND = 8'h14;
    localparam logic [7:0] ADDR_LIMIT = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1C;
    localparam logic [7:0] ADDR_CURRENT = 8'h20;
    localparam logic [7:0] ADDR_OUTPUT = 8'h24;

    // status register fields
    localparam int STATUS_STATE_LSB = 0;
    localparam int STATUS_SEL_BIT = 4;

    // ramp sequencer, gray coded along start, ramp, decel, hold, lock
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'h0,
        SEQ_START_HOLD = 3'h1,
        SEQ_RAMP = 3'h3,
        SEQ_DECEL = 3'h2,
        SEQ_STOP_HOLD = 3'h6,
        SEQ_LOCKED = 3'h7
    } state_e;

endpackage

// ===== control_source.sv
// upstream logic block that drives enable, select and stop
module control_source (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic enable_req_i,
    input wire logic select_req_i,
    input wire logic stop_req_i,
    output logic enable_o,
    output logic level_select_o,
    output logic decelerated_stop_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // outputs change once per scan, on the clock, like a real upstream block
    always_ff @(posedge sys_clk_i) begin
        enable_o <= enable_req_i & ~reset_i;
        level_select_o <= select_req_i & ~reset_i;
        decelerated_stop_o <= stop_req_i & ~reset_i;
    end
endmodule // control_source

// ===== testbench.sv
// self-checking bench for the analog ramp generator
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import analog_ramp_pkg::*;
    localparam int T = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic en = 1'b0;
    logic sel = 1'b0;
    logic stop = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready;
    logic en_d, sel_d, stop_d;
    level_t lvl;
    logic [15:0] out_val;
    logic hresp;
    int n_fail = 0;
    int n_checks = 0;
    int i;
    level_t re[11] = '{RATE_RST, GAIN_RST, OFFSET_RST, SS_RST, FIRST_RST, SECOND_RST,
        LIMIT_RST, 0, 0, 0, 0};
    logic [7:0] ta[12] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h08, 8'h0C, 8'h0C, 8'h0C, 8'h10,
        8'h10, 8'h14, 8'h14};
    level_t tv[12] = '{20000, 0, 100, -20000, 50, 30000, -5, 100, -30000, 175, 30000, 130};
    level_t te[12] = '{10000, 1, 100, -10000, 50, 20000, 0, 100, -10000, 175, 20000, 130};
    level_t gv[4] = '{300, 0, 3, 100};
    level_t ge[4] = '{41, 32767, 4166, 125};

    always #50 clk = ~clk;

    control_source control_source_i (.sys_clk_i(clk), .reset_i(rst), .enable_req_i(en),
        .select_req_i(sel), .stop_req_i(stop), .enable_o(en_d), .level_select_o(sel_d),
        .decelerated_stop_o(stop_d));
    analog_ramp_generator #(.TICK_CYCLES(T)) analog_ramp_generator_i (.sys_clk_i(clk),
        .reset_i(rst), .enable_i(en_d), .level_select_i(sel_d), .decelerated_stop_i(stop_d),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
        .hrdata_o(hrdata), .current_level_o(lvl), .scaled_output_value_o(out_val));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %0d seen %0d", nm, $signed(exp), $signed(seen));
        end
    endtask

    // one single-word transfer: address phase, then data phase
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
        chk("response", 32'(hresp), 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0, q);
        chk("register", q, e);
    endtask

    // wait a bounded number of cycles for the level, then compare
    task automatic wl(input level_t e, input int n);
        for (int k = 0; k < n && lvl !== e; k++) @(negedge clk);
        chk("level", lvl, e);
    endtask

    task automatic ctl(input logic e, input logic s, input logic p);
        @(posedge clk);
        en <= e;
        sel <= s;
        stop <= p;
    endtask

    task automatic results;
        if (n_fail == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        results();
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 11; i++) rdc(8'(i * 4), re[i]);
        wr(8'h28, 32'h0000_1234);
        wr(8'h20, 32'h0000_0055);
        rdc(8'h28, 32'h0);
        rdc(8'h20, 32'h0);
        for (i = 0; i < 12; i++) begin
            wr(ta[i], tv[i]);
            rdc(ta[i], te[i]);
        end
        ctl(1'b1, 1'b0, 1'b0);
        wl(150, 6);
        repeat (T - 6) @(negedge clk);
        chk("level", lvl, 150);
        wl(160, T + 8);
        wl(170, T + 2);
        wl(175, T + 2);
        for (i = 0; i < 4; i++) begin
            wr(8'h04, ge[i] == 0 ? 0 : gv[i]);
            repeat (4) @(negedge clk);
            chk("scaled", out_val, ge[i]);
        end
        chk("level", lvl, 175);
        rdc(8'h1C, 32'h3);
        ctl(1'b1, 1'b1, 1'b0);
        wl(165, T + 5);
        wl(130, 5 * T);
        rdc(8'h1C, 32'h13);
        ctl(1'b1, 1'b1, 1'b1);
        wl(140, T + 5);
        wl(150, T + 2);
        wl(50, 2 * T + 5);
        repeat (3) @(negedge clk);
        chk("scaled", out_val, 0);
        rdc(8'h1C, 32'h17);
        ctl(1'b0, 1'b1, 1'b1);
        repeat (4) @(negedge clk);
        ctl(1'b1, 1'b1, 1'b1);
        repeat (4) @(negedge clk);
        chk("level", lvl, 50);
        rdc(8'h1C, 32'h17);
        ctl(1'b1, 1'b1, 1'b0);
        repeat (2 * T) @(negedge clk);
        chk("level", lvl, 50);
        ctl(1'b0, 1'b1, 1'b0);
        repeat (2) @(posedge clk);
        ctl(1'b1, 1'b1, 1'b0);
        wl(150, 6);
        wl(140, 2 * T + 5);
        ctl(1'b0, 1'b1, 1'b0);
        wl(50, 5);
        wr(8'h18, 32'd20);
        wl(20, 5);
        repeat (3) @(negedge clk);
        chk("scaled", out_val, 0);
        results();
    end
endmodule // testbench
